// >>> pkg/blkcal_pkg.sv
// Constants, field positions and types shared by the black level calibration block
package blkcal_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [15:0] ADDR_ENABLE_CTRL  = 16'h4000; // Enable and debug
    localparam logic [15:0] ADDR_ROW_START    = 16'h4001; // First black row
    localparam logic [15:0] ADDR_RESET_CTRL   = 16'h4002; // Format trigger, source, frames
    localparam logic [15:0] ADDR_MANUAL_CTRL  = 16'h4003; // Manual trigger, freeze, frames
    localparam logic [15:0] ADDR_ROW_COUNT    = 16'h4004; // Black row count
    localparam logic [15:0] ADDR_LONG_TARGET  = 16'h4008; // Long channel level, read only
    localparam logic [15:0] ADDR_SHORT_TARGET = 16'h4009; // Short channel level, read only
    localparam logic [15:0] ADDR_RESERVED_LO  = 16'h4050; // Reserved, low byte
    localparam logic [15:0] ADDR_RESERVED_HI  = 16'h4051; // Reserved, high byte
    localparam logic [15:0] ADDR_TRIG_EN      = 16'h4055; // Per-channel trigger enables

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_ENABLE_CTRL = 8'h09;
    localparam logic [7:0] RST_ROW_START   = 8'h04;
    localparam logic [7:0] RST_RESET_CTRL  = 8'hC5;
    localparam logic [7:0] RST_MANUAL_CTRL = 8'h08;
    localparam logic [7:0] RST_ROW_COUNT   = 8'h08;
    localparam logic [7:0] RST_RESERVED    = 8'h00;
    localparam logic [7:0] RST_TRIG_EN     = 8'hFF;

    // ==========================================================
    // Field positions and widths
    localparam int BIT_ENABLE     = 0; // Calibration enable
    localparam int BIT_FMT_TRIG   = 7; // Format change triggers
    localparam int BIT_SRC_CALC   = 6; // 1: calculated offsets
    localparam int BIT_MAN_TRIG   = 7; // Manual trigger on rise
    localparam int BIT_FREEZE     = 6; // Hold offsets
    localparam int BIT_TEMP_SHORT = 6;
    localparam int BIT_EXP_SHORT  = 5;
    localparam int BIT_GAIN_SHORT = 4;
    localparam int BIT_TEMP_LONG  = 2;
    localparam int BIT_EXP_LONG   = 1;
    localparam int BIT_GAIN_LONG  = 0;
    localparam int FRAME_NUM_W    = 6; // Frame count fields [5:0]
    localparam int LINE_FIELD_W   = 5; // Row fields [4:0]
    localparam int LINE_IDX_W     = 6; // Row index, saturating

    // ==========================================================
    // Correction arithmetic
    localparam int FINE_W    = 6; // Fine range; coarse works in steps of 2**FINE_W
    localparam int IIR_SHIFT = 4; // Estimator smoothing

    // Calibration phase
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_RUN  = 1'b1
    } blkcal_phase_t;

endpackage : blkcal_pkg

// >>> src/blkcal_chan.sv
// One exposure channel: black estimate, offset hold and coarse/fine subtraction
`timescale 1ns/100ps
module blkcal_chan
    import blkcal_pkg::*;
#(
    parameter int PIX_W = 10
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_sample,     // Black pixel of this channel
    input  wire logic             i_commit,     // Frame done, take estimate
    input  wire logic             i_use_calc,   // Calculated or manual offset
    input  wire logic [PIX_W-1:0] i_pix_data,   // Pixel in
    input  wire logic [PIX_W-1:0] i_man_offset, // Software offset
    output logic      [PIX_W-1:0] o_offset,     // Offset in use
    output logic      [PIX_W-1:0] o_corrected   // Pixel after subtraction
);

    // ==========================================================
    // Saturating subtract, used for both stages
    function automatic logic [PIX_W-1:0] sub_sat(input logic [PIX_W-1:0] a,
                                                 input logic [PIX_W-1:0] b);
        sub_sat = (a > b) ? (a - b) : '0;
    endfunction : sub_sat

    logic [PIX_W-1:0] est;           // Running black estimate
    logic [PIX_W-1:0] next_est;
    logic [PIX_W-1:0] calc_off;      // Offset committed at frame edge
    logic [PIX_W-1:0] next_calc_off;
    logic signed [PIX_W:0] diff;     // Pixel minus estimate
    logic [PIX_W-1:0] coarse;        // Coarse part of offset
    logic [PIX_W-1:0] fine;          // Fine remainder

    // ==========================================================
    // Estimator: leaky average avoids a divider per frame
    always_comb
    begin
        diff          = $signed({1'b0, i_pix_data}) - $signed({1'b0, est});
        next_est      = est;
        next_calc_off = calc_off;
        if (i_sample)
            next_est = est + PIX_W'(diff >>> IIR_SHIFT);
        if (i_commit)
            next_calc_off = est;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            est      <= '0;
            calc_off <= '0;
        end
        else
        begin
            est      <= next_est;
            calc_off <= next_calc_off;
        end
    end

    // ==========================================================
    // Coarse step first, then fine remainder
    always_comb
    begin
        o_offset    = i_use_calc ? calc_off : i_man_offset;
        fine        = {{(PIX_W-FINE_W){1'b0}}, o_offset[FINE_W-1:0]};
        coarse      = o_offset - fine;
        o_corrected = sub_sat(sub_sat(i_pix_data, coarse), fine);
    end

endmodule : blkcal_chan

// >>> src/blkcal_top.sv
// Black level calibration: registers, trigger handling, frame sequencing, pixel path
//
// Function
// - Coarse then fine black offset subtraction
// - Reset and parameter changes start calibration
// - Manual start only on bit rising
// - Manual start runs manual frame count
// - Calibrate only while enable bit set
// - Black rows start at start-line field
// - Use line-count black rows for offset
// - Format change triggers only when enabled
// - Source bit picks manual or calculated
// - Reset start runs reset frame count
// - Freeze bit holds offsets unchanged
// - Long and short targets readable only
// - Short channel trigger enables, bits 6-4
// - Long channel trigger enables, bits 2-0
`timescale 1ns/100ps
module blkcal_top
    import blkcal_pkg::*;
#(
    parameter int PIX_W = 10
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Register port
    input  wire logic             i_reg_wr,         // Write strobe
    input  wire logic             i_reg_rd,         // Read strobe
    input  wire logic [15:0]      i_reg_addr,       // Register offset
    input  wire logic [7:0]       i_reg_wdata,      // Write data
    output logic      [7:0]       o_reg_rdata,      // Read data, next cycle
    // Change events from the sensor control, same clock
    input  wire logic             i_soft_rst,       // Soft reset pulse
    input  wire logic             i_gain_chg_long,
    input  wire logic             i_exp_chg_long,
    input  wire logic             i_temp_chg_long,
    input  wire logic             i_gain_chg_short,
    input  wire logic             i_exp_chg_short,
    input  wire logic             i_temp_chg_short,
    input  wire logic             i_fmt_chg,        // Output format changed
    // Manual offsets
    input  wire logic [PIX_W-1:0] i_man_offset_long,
    input  wire logic [PIX_W-1:0] i_man_offset_short,
    // Pixel stream from array readout
    input  wire logic             i_pix_valid,
    input  wire logic             i_pix_sof,        // First pixel of frame
    input  wire logic             i_pix_sol,        // First pixel of line
    input  wire logic             i_pix_long,       // 1: long exposure pixel
    input  wire logic [PIX_W-1:0] i_pix_data,
    // Pixel stream to image pipeline
    output logic                  o_pix_valid,
    output logic                  o_pix_sof,
    output logic                  o_pix_sol,
    output logic                  o_pix_long,
    output logic      [PIX_W-1:0] o_pix_data,
    output logic                  o_cal_busy        // Calibration in progress
);

    // ==========================================================
    // Reset release through two flops
    logic rst_meta;   // First stage, read only by second
    logic rst_sync_n; // Internal reset

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ==========================================================
    // Register file
    logic [7:0] enable_ctrl, next_enable_ctrl;   // Enable and debug
    logic [7:0] row_start, next_row_start;       // Black row start
    logic [7:0] reset_ctrl, next_reset_ctrl;     // Format, source, frames
    logic [7:0] manual_ctrl, next_manual_ctrl;   // Trigger, freeze, frames
    logic [7:0] row_count, next_row_count;       // Black row count
    logic [7:0] resv_lo, next_resv_lo;           // Reserved storage
    logic [7:0] resv_hi, next_resv_hi;
    logic [7:0] trig_en, next_trig_en;           // Trigger enables
    logic [7:0] rdata, next_rdata;               // Read data register
    logic       man_rise;                        // Manual bit rose this write
    logic [PIX_W-1:0] off_long, off_short;       // Offsets in use

    // Clamp a channel level into the 8-bit read-back
    function automatic logic [7:0] sat8(input logic [PIX_W-1:0] v);
        sat8 = (v > PIX_W'(8'hFF)) ? 8'hFF : v[7:0];
    endfunction : sat8

    // Write decode and read mux
    always_comb
    begin
        next_enable_ctrl = enable_ctrl;
        next_row_start   = row_start;
        next_reset_ctrl  = reset_ctrl;
        next_manual_ctrl = manual_ctrl;
        next_row_count   = row_count;
        next_resv_lo     = resv_lo;
        next_resv_hi     = resv_hi;
        next_trig_en     = trig_en;
        next_rdata       = rdata;
        if (i_reg_wr)
            case (i_reg_addr)
                ADDR_ENABLE_CTRL: next_enable_ctrl = i_reg_wdata;
                ADDR_ROW_START:   next_row_start   = i_reg_wdata;
                ADDR_RESET_CTRL:  next_reset_ctrl  = i_reg_wdata;
                ADDR_MANUAL_CTRL: next_manual_ctrl = i_reg_wdata;
                ADDR_ROW_COUNT:   next_row_count   = i_reg_wdata;
                // Kept as plain storage; software is expected not to touch them
                ADDR_RESERVED_LO: next_resv_lo     = i_reg_wdata;
                ADDR_RESERVED_HI: next_resv_hi     = i_reg_wdata;
                ADDR_TRIG_EN:     next_trig_en     = i_reg_wdata;
                default:          ; // Read-only and unmapped writes ignored
            endcase
        if (i_reg_rd)
            case (i_reg_addr)
                ADDR_ENABLE_CTRL:  next_rdata = enable_ctrl;
                ADDR_ROW_START:    next_rdata = row_start;
                ADDR_RESET_CTRL:   next_rdata = reset_ctrl;
                ADDR_MANUAL_CTRL:  next_rdata = manual_ctrl;
                ADDR_ROW_COUNT:    next_rdata = row_count;
                ADDR_LONG_TARGET:  next_rdata = sat8(off_long);
                ADDR_SHORT_TARGET: next_rdata = sat8(off_short);
                ADDR_RESERVED_LO:  next_rdata = resv_lo;
                ADDR_RESERVED_HI:  next_rdata = resv_hi;
                ADDR_TRIG_EN:      next_rdata = trig_en;
                default:           next_rdata = 8'h00; // Unmapped reads zero
            endcase
        // Only a 0 to 1 change of the bit starts a manual run
        man_rise = i_reg_wr && i_reg_addr == ADDR_MANUAL_CTRL
                   && !manual_ctrl[BIT_MAN_TRIG] && i_reg_wdata[BIT_MAN_TRIG];
    end
    always_ff @(posedge i_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            enable_ctrl <= RST_ENABLE_CTRL;
            row_start   <= RST_ROW_START;
            reset_ctrl  <= RST_RESET_CTRL;
            manual_ctrl <= RST_MANUAL_CTRL;
            row_count   <= RST_ROW_COUNT;
            resv_lo     <= RST_RESERVED;
            resv_hi     <= RST_RESERVED;
            trig_en     <= RST_TRIG_EN;
            rdata       <= 8'h00;
        end
        else
        begin
            enable_ctrl <= next_enable_ctrl;
            row_start   <= next_row_start;
            reset_ctrl  <= next_reset_ctrl;
            manual_ctrl <= next_manual_ctrl;
            row_count   <= next_row_count;
            resv_lo     <= next_resv_lo;
            resv_hi     <= next_resv_hi;
            trig_en     <= next_trig_en;
            rdata       <= next_rdata;
        end
    end

    assign o_reg_rdata = rdata;

    // ==========================================================
    // Trigger collection and frame sequencing
    logic          cal_en, freeze, frame_edge;
    logic          auto_evt;                     // Any enabled change event, or a soft reset (not gated)
    logic          pend_rst, next_pend_rst;      // Reset-type start pending
    logic          pend_man, next_pend_man;      // Manual start pending
    blkcal_phase_t phase, next_phase;
    logic [FRAME_NUM_W-1:0] frames_left, next_frames_left;
    logic          seen, next_seen;              // A sampled frame is open
    logic          commit;                       // Take estimates now

    // Events latch until the next frame edge; a new one wins over the consume
    always_comb
    begin
        cal_en     = enable_ctrl[BIT_ENABLE];
        freeze     = manual_ctrl[BIT_FREEZE];
        frame_edge = i_pix_valid && i_pix_sof;
        auto_evt   = (i_temp_chg_short && trig_en[BIT_TEMP_SHORT])
                   || (i_exp_chg_short && trig_en[BIT_EXP_SHORT])
                   || (i_gain_chg_short && trig_en[BIT_GAIN_SHORT])
                   || (i_temp_chg_long && trig_en[BIT_TEMP_LONG])
                   || (i_exp_chg_long && trig_en[BIT_EXP_LONG])
                   || (i_gain_chg_long && trig_en[BIT_GAIN_LONG])
                   || (i_fmt_chg && reset_ctrl[BIT_FMT_TRIG])
                   || i_soft_rst;
        next_pend_rst    = (pend_rst && !frame_edge) || auto_evt;
        next_pend_man    = (pend_man && !frame_edge) || man_rise;
        next_phase       = phase;
        next_frames_left = frames_left;
        next_seen        = seen;
        commit           = 1'b0;
        if (frame_edge)
        begin
            // Close the frame just sampled unless frozen or disabled
            if (phase == PH_RUN && seen && cal_en && !freeze)
            begin
                commit           = 1'b1;
                next_frames_left = frames_left - 1'b1;
                if (frames_left == FRAME_NUM_W'(1))
                    next_phase = PH_IDLE;
            end
            // A pending start reloads the run, manual taking precedence
            if (cal_en && pend_man)
            begin
                next_frames_left = manual_ctrl[FRAME_NUM_W-1:0];
                next_phase = (manual_ctrl[FRAME_NUM_W-1:0] != '0) ? PH_RUN : PH_IDLE;
            end
            else if (cal_en && pend_rst)
            begin
                next_frames_left = reset_ctrl[FRAME_NUM_W-1:0];
                next_phase = (reset_ctrl[FRAME_NUM_W-1:0] != '0) ? PH_RUN : PH_IDLE;
            end
            next_seen = 1'b1;
        end
        if (!cal_en)
            next_seen = 1'b0;
    end
    always_ff @(posedge i_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pend_rst    <= 1'b1; // Hard reset starts calibration
            pend_man    <= 1'b0;
            phase       <= PH_IDLE;
            frames_left <= '0;
            seen        <= 1'b0;
        end
        else
        begin
            pend_rst    <= next_pend_rst;
            pend_man    <= next_pend_man;
            phase       <= next_phase;
            frames_left <= next_frames_left;
            seen        <= next_seen;
        end
    end

    // ==========================================================
    // Line counting and black row window
    logic [LINE_IDX_W-1:0] line_idx, next_line_idx; // Saturates, rows past window ignored
    logic [LINE_IDX_W-1:0] win_lo, win_hi;
    logic                  black_row, sample_ok;

    always_comb
    begin
        next_line_idx = line_idx;
        if (frame_edge)
            next_line_idx = '0;
        else if (i_pix_valid && i_pix_sol && line_idx != '1)
            next_line_idx = line_idx + 1'b1;
        win_lo    = LINE_IDX_W'(row_start[LINE_FIELD_W-1:0]);
        win_hi    = win_lo + LINE_IDX_W'(row_count[LINE_FIELD_W-1:0]);
        black_row = (next_line_idx >= win_lo) && (next_line_idx < win_hi);
        sample_ok = i_pix_valid && black_row && phase == PH_RUN
                    && cal_en && !freeze;
    end
    always_ff @(posedge i_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            line_idx <= '0;
        else
            line_idx <= next_line_idx;
    end

    // ==========================================================
    // Per-channel estimators and correction
    logic [PIX_W-1:0] corr_long, corr_short;

    blkcal_chan #(.PIX_W(PIX_W)) u_long (
        .i_clk        (i_clk),
        .i_rst_n      (rst_sync_n),
        .i_sample     (sample_ok && i_pix_long),
        .i_commit     (commit),
        .i_use_calc   (reset_ctrl[BIT_SRC_CALC]),
        .i_pix_data   (i_pix_data),
        .i_man_offset (i_man_offset_long),
        .o_offset     (off_long),
        .o_corrected  (corr_long)
    );

    blkcal_chan #(.PIX_W(PIX_W)) u_short (
        .i_clk        (i_clk),
        .i_rst_n      (rst_sync_n),
        .i_sample     (sample_ok && !i_pix_long),
        .i_commit     (commit),
        .i_use_calc   (reset_ctrl[BIT_SRC_CALC]),
        .i_pix_data   (i_pix_data),
        .i_man_offset (i_man_offset_short),
        .o_offset     (off_short),
        .o_corrected  (corr_short)
    );

    // ==========================================================
    // Output stage: one cycle of latency, all flags kept aligned
    logic             nv, ns, nl, nlong, nbusy;
    logic [PIX_W-1:0] nd;
    always_comb
    begin
        nv    = i_pix_valid;
        ns    = i_pix_valid && i_pix_sof;
        nl    = i_pix_valid && i_pix_sol;
        nlong = i_pix_long;
        nd    = i_pix_valid ? (i_pix_long ? corr_long : corr_short) : o_pix_data;
        nbusy = (next_phase == PH_RUN);
    end
    always_ff @(posedge i_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            o_pix_valid <= 1'b0;
            o_pix_sof   <= 1'b0;
            o_pix_sol   <= 1'b0;
            o_pix_long  <= 1'b0;
            o_pix_data  <= '0;
            o_cal_busy  <= 1'b0;
        end
        else
        begin
            o_pix_valid <= nv;
            o_pix_sof   <= ns;
            o_pix_sol   <= nl;
            o_pix_long  <= nlong;
            o_pix_data  <= nd;
            o_cal_busy  <= nbusy;
        end
    end

endmodule : blkcal_top

// >>> sim/blkcal_assertions.sv
// Port checker for black level calibration
`timescale 1ns/100ps
module blkcal_assertions
    import blkcal_pkg::*;
#(
    parameter int PIX_W = 10
)(
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_reg_rd,
    input wire logic [7:0]       o_reg_rdata,
    input wire logic             i_pix_valid,
    input wire logic             i_pix_sof,
    input wire logic             i_pix_sol,
    input wire logic             i_pix_long,
    input wire logic [PIX_W-1:0] i_pix_data,
    input wire logic             o_pix_valid,
    input wire logic             o_pix_sof,
    input wire logic             o_pix_sol,
    input wire logic             o_pix_long,
    input wire logic [PIX_W-1:0] o_pix_data,
    input wire logic             o_cal_busy
);
    // ==========================================================
    // Properties, one clock domain
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // First pixel of a frame taken
    sequence s_frame_start;
        i_pix_valid && i_pix_sof;
    endsequence
    AST_VALID_COPY: assert property (i_pix_valid |=> o_pix_valid)
        else $error("valid not passed on");
    AST_IDLE_HOLD: assert property (!i_pix_valid |=> !o_pix_valid && $stable(o_pix_data))
        else $error("output moved without a pixel");
    AST_SOF_COPY: assert property (s_frame_start |=> o_pix_sof)
        else $error("frame start not passed on");
    AST_SOF_ONLY: assert property (!(i_pix_valid && i_pix_sof) |=> !o_pix_sof)
        else $error("frame start without cause");
    AST_FLAGS_COPY: assert property (i_pix_valid |=> o_pix_sol == $past(i_pix_sol)
        && o_pix_long == $past(i_pix_long)) else $error("line or channel flag wrong");
    AST_SUBTRACT: assert property (i_pix_valid |=> o_pix_data <= $past(i_pix_data))
        else $error("pixel above input");
    AST_RDATA_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved");
    AST_BUSY_START: assert property (!o_cal_busy && !(i_pix_valid && i_pix_sof)
        |=> !o_cal_busy) else $error("run started off a frame start");
endmodule : blkcal_assertions

// >>> sim/blkcal_pixsrc.sv
// Pixel array readout model: frames of dark and active rows
`timescale 1ns/100ps
module blkcal_pixsrc #(
    parameter int PIX_W = 10
)(
    input  wire logic             i_clk,
    output logic                  o_valid,
    output logic                  o_sof,
    output logic                  o_sol,
    output logic                  o_long,
    output logic      [PIX_W-1:0] o_data
);
    // ==========================================================
    // Pixel driving, always just after a rising edge
    initial {o_valid, o_sof, o_sol, o_long, o_data} = '0;
    task automatic pix(input logic f, input logic l, input logic g, input logic [PIX_W-1:0] d);
        @(posedge i_clk);
        #1;
        {o_valid, o_sof, o_sol, o_long, o_data} = {1'b1, f, l, g, d};
    endtask : pix
    // Released data toggles so a stale value never passes for a pixel
    task automatic idle();
        @(posedge i_clk);
        #1;
        {o_valid, o_sof, o_sol} = 3'b000;
        o_data = ~o_data;
    endtask : idle
    // 14 rows of 4 pixels, channels alternate; rows 0 to 11 are dark
    task automatic frame(input logic [PIX_W-1:0] b);
        for (int r = 0; r < 14; r++)
            for (int c = 0; c < 4; c++)
                pix(r == 0 && c == 0, r != 0 && c == 0, c % 2 == 0, (r < 12) ? b : 10'h200);
        idle();
    endtask : frame
endmodule : blkcal_pixsrc

// >>> sim/tb_top.sv
// Testbench for the black level calibration block
`timescale 1ns/100ps
module tb_top;
    import blkcal_pkg::*;
    localparam int PIX_W = 10;
    // ==========================================================
    // Signals named as the ports
    logic             i_clk              = 1'b0;
    logic             i_rst_n            = 1'b0;
    logic             i_reg_wr           = 1'b0;
    logic             i_reg_rd           = 1'b0;
    logic             i_soft_rst         = 1'b0;
    logic [15:0]      i_reg_addr         = 16'h0000;
    logic [7:0]       i_reg_wdata        = 8'h00;
    logic [6:0]       ev                 = 7'h00;  // Bit k is trigger enable k; 3 is format
    logic [PIX_W-1:0] i_man_offset_long  = 10'h040; // Coarse part only
    logic [PIX_W-1:0] i_man_offset_short = 10'h050; // Coarse and fine parts
    logic [7:0]       o_reg_rdata, rd, t0;
    logic [PIX_W-1:0] i_pix_data, o_pix_data;
    logic             i_pix_valid, i_pix_sof, i_pix_sol, i_pix_long, o_cal_busy;
    logic             o_pix_valid, o_pix_sof, o_pix_sol, o_pix_long;
    int               n_errors           = 0;
    int               tests_run          = 0;
    logic [15:0]      ad [9] = '{16'h4000, 16'h4001, 16'h4002, 16'h4003, 16'h4004,
                                 16'h4008, 16'h4009, 16'h4055, 16'h4060};
    logic [7:0]       ex [9] = '{8'h09, 8'h04, 8'hC5, 8'h08, 8'h08, 8'h00, 8'h00, 8'hFF, 8'h00};
    always #4 i_clk = ~i_clk;
    blkcal_pixsrc #(.PIX_W(PIX_W)) i_blkcal_pixsrc (.i_clk(i_clk), .o_valid(i_pix_valid),
        .o_sof(i_pix_sof), .o_sol(i_pix_sol), .o_long(i_pix_long), .o_data(i_pix_data));
    blkcal_top #(.PIX_W(PIX_W)) i_blkcal_top (.*, .i_gain_chg_long(ev[0]),
        .i_exp_chg_long(ev[1]), .i_temp_chg_long(ev[2]), .i_fmt_chg(ev[3]),
        .i_gain_chg_short(ev[4]), .i_exp_chg_short(ev[5]), .i_temp_chg_short(ev[6]));
    // ==========================================================
    // Compare, bus and stream tasks
    task automatic chkv(input logic [PIX_W-1:0] got, input logic [PIX_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chkv
    task automatic chkb(input logic got, input logic exp);
        chkv({9'h000, got}, {9'h000, exp});
    endtask : chkb
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        @(posedge i_clk);
        #1;
        i_reg_wr = 1'b0;
    endtask : wr
    // Data is taken one cycle after the read edge
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(posedge i_clk);
        #1;
        i_reg_rd = 1'b0;
        d = o_reg_rdata;
    endtask : rd8
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        rd8(a, rd);
        chkv({2'b00, rd}, {2'b00, e});
    endtask : rc
    task automatic pulse(input logic [6:0] e, input logic s);
        @(posedge i_clk);
        #1;
        {ev, i_soft_rst} = {e, s};
        @(posedge i_clk);
        #1;
        {ev, i_soft_rst} = 8'h00;
    endtask : pulse
    // Runs of frames, then the busy flag
    task automatic fb(input int n, input logic e);
        repeat (n) i_blkcal_pixsrc.frame(10'h020);
        chkb(o_cal_busy, e);
    endtask : fb
    task automatic pxc(input logic g, input logic [PIX_W-1:0] d, input logic [PIX_W-1:0] e);
        i_blkcal_pixsrc.pix(1'b0, 1'b0, g, d);
        i_blkcal_pixsrc.idle();
        chkv(o_pix_data, e);
    endtask : pxc
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (5) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < 9; k++)
            rc(ad[k], ex[k]);
        wr(ADDR_LONG_TARGET, 8'h55);
        rc(ADDR_LONG_TARGET, 8'h00);
        $display("test registers done");
        fb(1, 1'b1);
        fb(4, 1'b1);
        fb(1, 1'b0);
        rd8(ADDR_LONG_TARGET, rd);
        chkb(rd >= 8'h08 && rd <= 8'h20, 1'b1);
        wr(ADDR_RESET_CTRL, 8'h05);
        rc(ADDR_SHORT_TARGET, 8'h50);
        pxc(1'b1, 10'h100, 10'h0C0);
        pxc(1'b0, 10'h100, 10'h0B0);
        pxc(1'b0, 10'h048, 10'h000);
        $display("test reset run and offsets done");
        wr(ADDR_MANUAL_CTRL, 8'h82);
        fb(1, 1'b1);
        fb(1, 1'b1);
        fb(1, 1'b0);
        wr(ADDR_MANUAL_CTRL, 8'h82);
        fb(1, 1'b0);
        $display("test manual trigger done");
        wr(ADDR_RESET_CTRL, 8'h41);
        wr(ADDR_TRIG_EN, 8'h88); // Debug bits stay set
        pulse(7'h7F, 1'b0);
        fb(1, 1'b0);
        wr(ADDR_RESET_CTRL, 8'hC1);
        wr(ADDR_TRIG_EN, 8'hFF);
        for (int k = 0; k < 7; k++)
        begin
            pulse(7'h01 << k, 1'b0);
            chkb(o_cal_busy, 1'b0);
            fb(1, 1'b1);
            fb(1, 1'b0);
        end
        wr(ADDR_ENABLE_CTRL, 8'h08);
        pulse(7'h00, 1'b1);
        fb(1, 1'b0);
        wr(ADDR_ENABLE_CTRL, 8'h09);
        $display("test triggers done");
        wr(ADDR_RESET_CTRL, 8'h45);
        wr(ADDR_MANUAL_CTRL, 8'h40);
        rd8(ADDR_LONG_TARGET, t0);
        pulse(7'h00, 1'b1);
        repeat (2) i_blkcal_pixsrc.frame(10'h0F0);
        rc(ADDR_LONG_TARGET, t0);
        $display("test freeze done");
        summarize();
    end
    // Cut a hang short; the sequence needs about 13.5 us
    initial
    begin
        #100000;
        n_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end
endmodule : tb_top
bind blkcal_top blkcal_assertions #(.PIX_W(PIX_W)) i_blkcal_assertions (.*);
